// [design/uprpp_pkg.sv]
// Purpose: shared constants for the printer-port strobe engine
// Assumes: sys_clk at 250 MHz
// Notes:   times kept in ns or ms; cycle counts derived from the clock rate
package uprpp_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  // ==========================================================
  // reset timing
  localparam int unsigned POR_TIME_MS     = 20;
  localparam int unsigned EXT_DELAY_MS    = 30;
  localparam int unsigned EXT_MIN_NS      = 100;
  localparam int unsigned POR_CYCLES      = POR_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned EXT_DELAY_CYC   = EXT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned EXT_MIN_CYC     = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // print timing, ns
  localparam int unsigned LOW_SLOW_NS     = 840;
  localparam int unsigned LOW_FAST_NS     = 420;
  localparam int unsigned HIGH_SLOW_NS    = 800;
  localparam int unsigned HIGH_FAST_NS    = 560;
  localparam int unsigned SETUP_NS        = 240;
  localparam int unsigned HOLD_NS         = 240;
  localparam int unsigned BUSY_GAP_NS     = 160;
  localparam int unsigned ACK_GAP_NS      = 160;
  // least times round up
  localparam int unsigned LOW_SLOW_CYC    = (LOW_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOW_FAST_CYC    = (LOW_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_SLOW_CYC   = (HIGH_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_FAST_CYC   = (HIGH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_GAP_CYC    = (BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_GAP_CYC     = (ACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // widths
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned TIM_W           = 8;
  localparam logic [TIM_W-1:0] TIM_ONE    = 8'h01;
  localparam logic [7:0]  DATA_RST        = 8'h00;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    UPRPP_RESET = 3'b000,
    UPRPP_IDLE  = 3'b001,
    UPRPP_SETUP = 3'b010,
    UPRPP_LOW   = 3'b011,
    UPRPP_HOLD  = 3'b100,
    UPRPP_WAIT  = 3'b101
  } uprpp_state_type;
endpackage

// [design/uprpp_top.sv]
// Purpose: parallel printer-port strobe engine with reset delays and strap
// Assumes: all inputs synchronous to sys_clk; printer keeps its handshake
// Notes:   one byte per request; high-speed mode ignores ack
//
// Function
// - the logic runs from one fixed clock, here sys_clk, with all times as cycle counts.
// - after power-up the port stays in reset for the power-up delay before working.
// - after a valid external reset the port stays in reset for the 30 ms delay.
// - the strobe is low for 840 ns in low speed and 420 ns in high speed, never over 10000 ns.
// - the strobe stays high at least 800 ns low speed and 560 ns high speed between pulses.
// - data is on the bus at least 240 ns before the strobe falls.
// - data stays stable at least 240 ns after the strobe rises.
// - a strobe starts no sooner than 160 ns after busy falls.
// - in low speed, a strobe starts no sooner than 160 ns after ack rises.
// - serial clock and data tied together, with the data pin read low, at startup selects printer port mode.
// - serial clock and data both floating at startup selects serial mode instead.
// - low-speed mode waits on both ack and busy before the next byte.
// - a low-speed and a high-speed print mode are selectable.
`timescale 1ns/10ps
`default_nettype none
module uprpp_top
  import uprpp_pkg::*;
#(
  parameter int unsigned POR_CYC   = POR_CYCLES,
  parameter int unsigned EXTD_CYC  = EXT_DELAY_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ext_reset_in,
  input  wire logic       high_speed,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       sda_drive_in,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       busy,
  input  wire logic       ack_n,
  output logic            tx_ready,
  output logic [7:0]      pdata,
  output logic            data_strobe_n,
  output logic            printer_mode,
  output logic            serial_mode,
  output logic            port_active
);
  uprpp_state_type    state_r;
  logic [CNT_W-1:0]   rst_cnt_r;
  logic [TIM_W-1:0]   ext_cnt_r;
  logic [TIM_W-1:0]   tim_r;
  logic [TIM_W-1:0]   busy_gap_r;
  logic [TIM_W-1:0]   ack_gap_r;
  logic               ext_valid;
  logic               mode_r;
  logic               slow_low;

  // ==========================================================
  // external reset qualification: held long enough to count
  // a glitch shorter than the minimum width leaves the port alone;
  // the count saturates so a long hold keeps ext_valid standing
  assign ext_valid = (ext_cnt_r >= TIM_W'(EXT_MIN_CYC));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_cnt_r <= '0;
    end else if (ext_reset_in) begin
      if (!ext_valid) begin
        ext_cnt_r <= ext_cnt_r + TIM_ONE;
      end
    end else begin
      ext_cnt_r <= '0;
    end
  end

  // ==========================================================
  // reset hold counter: power-up then external delay
  // reloaded for as long as a qualified external reset stands,
  // so the delay is reckoned from its release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= '0;
    end else if (ext_valid) begin
      rst_cnt_r <= CNT_W'(EXTD_CYC);
    end else if (state_r == UPRPP_RESET && rst_cnt_r == '0 && !port_active) begin
      rst_cnt_r <= CNT_W'(POR_CYC);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - CNT_W'(1);
    end
  end

  // ==========================================================
  // strap capture while in reset, serial lines tied with the data pin read low selects printer
  // sampled on every reset cycle so the last level before the port
  // wakes counts in printer mode, while in serial mode sampling goes on after the port wakes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
    end else if (state_r == UPRPP_RESET) begin
      mode_r <= (scl_in == sda_drive_in) && !sda_in;
    end
  end

  // ==========================================================
  // gap timers since busy fell and ack rose
  // each timer is reloaded while its line is still active, so it stands
  // full on the first edge that sees the line released and no strobe
  // can start in that same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_gap_r <= '0;
      ack_gap_r  <= '0;
    end else begin
      // busy high holds its timer full
      if (busy) begin
        busy_gap_r <= TIM_W'(BUSY_GAP_CYC);
      end else if (busy_gap_r != '0) begin
        busy_gap_r <= busy_gap_r - TIM_ONE;
      end
      // ack low holds its timer full
      if (!ack_n) begin
        ack_gap_r <= TIM_W'(ACK_GAP_CYC);
      end else if (ack_gap_r != '0) begin
        ack_gap_r <= ack_gap_r - TIM_ONE;
      end
    end
  end

  assign slow_low = !high_speed;

  // ==========================================================
  // strobe sequencer
  // held in reset while a qualified external reset stands or the
  // hold counter runs; port_active rises on the counter's last cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= UPRPP_RESET;
      tim_r         <= '0;
      pdata         <= DATA_RST;
      data_strobe_n <= 1'b1;
      tx_ready      <= 1'b0;
      port_active   <= 1'b0;
    end else if (ext_valid || (state_r == UPRPP_RESET && rst_cnt_r != '0)
                 || (state_r == UPRPP_RESET && !port_active && rst_cnt_r == '0)) begin
      state_r       <= UPRPP_RESET;
      data_strobe_n <= 1'b1;
      tx_ready      <= 1'b0;
      port_active   <= ext_valid ? 1'b0 : (rst_cnt_r == CNT_W'(1));
    end else begin
      port_active <= 1'b1;
      unique case (state_r)
        UPRPP_RESET: begin
          if (mode_r) begin
            state_r  <= UPRPP_IDLE;
            tx_ready <= 1'b1;
          end
        end
        UPRPP_IDLE: begin
          if (tx_valid && tx_ready) begin
            pdata    <= tx_data;
            tx_ready <= 1'b0;
            tim_r    <= TIM_W'(SETUP_CYC);
            state_r  <= UPRPP_SETUP;
          end
        end
        UPRPP_SETUP: begin
          // handshake gates looked at only once set-up has run out
          if (tim_r > TIM_ONE) begin
            tim_r <= tim_r - TIM_ONE;
          end else if (!busy && busy_gap_r == '0
                       && (!slow_low || (ack_n && ack_gap_r == '0))) begin
            data_strobe_n <= 1'b0;
            tim_r         <= slow_low ? TIM_W'(LOW_SLOW_CYC) : TIM_W'(LOW_FAST_CYC);
            state_r       <= UPRPP_LOW;
          end
        end
        UPRPP_LOW: begin
          if (tim_r > TIM_ONE) begin
            tim_r <= tim_r - TIM_ONE;
          end else begin
            data_strobe_n <= 1'b1;
            tim_r         <= TIM_W'(HOLD_CYC);
            state_r       <= UPRPP_HOLD;
          end
        end
        UPRPP_HOLD: begin
          if (tim_r > TIM_ONE) begin
            tim_r <= tim_r - TIM_ONE;
          end else begin
            // remaining high time beyond the hold
            tim_r   <= slow_low ? TIM_W'(HIGH_SLOW_CYC - HOLD_CYC)
                                : TIM_W'(HIGH_FAST_CYC - HOLD_CYC);
            state_r <= UPRPP_WAIT;
          end
        end
        UPRPP_WAIT: begin
          if (tim_r > TIM_ONE) begin
            tim_r <= tim_r - TIM_ONE;
          end else begin
            tx_ready <= 1'b1;
            state_r  <= UPRPP_IDLE;
          end
        end
        default: begin
          state_r <= UPRPP_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // function strap outputs
  // only updated while the port is awake, so both read low until it first wakes and hold through an external reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      printer_mode <= 1'b0;
      serial_mode  <= 1'b0;
    end else if (port_active) begin
      printer_mode <= mode_r;
      serial_mode  <= !mode_r;
    end
  end
endmodule
`default_nettype wire

// [testbench/uprpp_monitor.sv]
// Purpose: timing checks on the strobe port
// Assumes: bound to uprpp_top
// Notes:   spans counted in sys_clk cycles
`timescale 1ns/10ps
`default_nettype none
module uprpp_monitor
  import uprpp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       high_speed,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       busy,
  input wire logic       ack_n,
  input wire logic       tx_ready,
  input wire logic [7:0] pdata,
  input wire logic       data_strobe_n,
  input wire logic       serial_mode,
  input wire logic       port_active
);
  logic [15:0] lo_c, hi_c, bz_c, ak_c, pd_c;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [15:0] up(input logic k, input logic [15:0] c);
    return k ? c + 16'(c != 16'hffff) : 16'h0000;
  endfunction
  // ==========
  // cycles each level has lasted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_c <= 16'h0000;
      hi_c <= 16'hffff;
      bz_c <= 16'hffff;
      ak_c <= 16'hffff;
      pd_c <= 16'hffff;
    end else begin
      lo_c <= up(!data_strobe_n, lo_c);
      hi_c <= up(data_strobe_n, hi_c);
      bz_c <= up(!busy, bz_c);
      ak_c <= up(ack_n, ak_c);
      pd_c <= up(!$changed(pdata), pd_c);
    end
  end
  sequence take_s;
    tx_valid && tx_ready;
  endsequence
  // ==========
  // port rules
  strobe_low_a: assert property (
    $rose(data_strobe_n) |-> lo_c == (high_speed ? LOW_FAST_CYC : LOW_SLOW_CYC))
    else $error("strobe low width");
  strobe_high_a: assert property (
    $fell(data_strobe_n) |-> hi_c >= (high_speed ? HIGH_FAST_CYC : HIGH_SLOW_CYC))
    else $error("strobe high width");
  data_setup_a: assert property ($fell(data_strobe_n) |-> pd_c >= SETUP_CYC - 1)
    else $error("data setup");
  data_hold_a: assert property ($changed(pdata) |-> hi_c >= HOLD_CYC)
    else $error("data hold");
  busy_gap_a: assert property ($fell(data_strobe_n) |-> bz_c >= BUSY_GAP_CYC)
    else $error("busy gap");
  ack_gap_a: assert property (
    $fell(data_strobe_n) && !high_speed |-> ak_c >= ACK_GAP_CYC)
    else $error("ack gap");
  byte_take_a: assert property (take_s |=> !tx_ready && pdata == $past(tx_data))
    else $error("byte take");
  serial_idle_a: assert property (serial_mode |-> !tx_ready)
    else $error("serial ready");
  reset_hold_a: assert property (!port_active |-> data_strobe_n && !tx_ready)
    else $error("port not held");
endmodule
bind uprpp_top uprpp_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .high_speed(high_speed), .tx_valid(tx_valid), .tx_data(tx_data), .busy(busy),
  .ack_n(ack_n), .tx_ready(tx_ready), .pdata(pdata), .data_strobe_n(data_strobe_n),
  .serial_mode(serial_mode), .port_active(port_active));
`default_nettype wire

// [testbench/uprpp_printer.sv]
// Purpose: printer side of the strobe handshake
// Assumes: busy stands twice dly plus 30 cycles
// Notes:   ack pulse 30 cycles, busy drops with it
`timescale 1ns/10ps
`default_nettype none
module uprpp_printer (
  input wire logic       clk,
  input wire logic       data_strobe_n,
  input wire logic [7:0] pdata,
  input wire logic [7:0] dly,
  output var logic       busy,
  output var logic       ack_n,
  output var logic [7:0] got
);
  // ==========
  // take byte, stay busy, pulse ack
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    got = 8'h00;
    forever begin
      @(negedge data_strobe_n);
      got = pdata;
      @(negedge clk);
      busy = 1'b1;
      repeat (2 * dly) @(negedge clk);
      ack_n = 1'b0;
      repeat (30) @(negedge clk);
      ack_n = 1'b1;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [testbench/usb_printer_parallel_port_tb_top.sv]
// Purpose: self-checking bench for the printer strobe port
// Assumes: reset delays cut to 50 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module usb_printer_parallel_port_tb_top;
  import uprpp_pkg::*;
  logic sys_clk, rst_n, ext_reset_in, high_speed, scl_in, sda_in, sda_drive_in;
  logic tx_valid, busy, ack_n, tx_ready, data_strobe_n, printer_mode;
  logic serial_mode, port_active;
  logic [7:0] tx_data, pdata, dly, got;
  int error_cnt = 0;
  int cmp_count = 0;
  uprpp_top #(.POR_CYC(50), .EXTD_CYC(50)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .ext_reset_in(ext_reset_in), .high_speed(high_speed), .scl_in(scl_in),
    .sda_in(sda_in), .sda_drive_in(sda_drive_in), .tx_valid(tx_valid),
    .tx_data(tx_data), .busy(busy), .ack_n(ack_n), .tx_ready(tx_ready),
    .pdata(pdata), .data_strobe_n(data_strobe_n), .printer_mode(printer_mode),
    .serial_mode(serial_mode), .port_active(port_active));
  uprpp_printer u_prn (.clk(sys_clk), .data_strobe_n(data_strobe_n), .pdata(pdata),
    .dly(dly), .busy(busy), .ack_n(ack_n), .got(got));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic t_send(input logic hs, input logic [7:0] b);
    int i;
    int lo;
    for (i = 0; i < 3000 && tx_ready !== 1'b1; i++) @(negedge sys_clk);
    high_speed = hs;
    tx_valid = 1'b1;
    tx_data = b;
    @(negedge sys_clk);
    tx_valid = 1'b0;
    for (i = 0; i < 3000 && data_strobe_n !== 1'b0; i++) @(negedge sys_clk);
    for (lo = 0; lo < 3000 && data_strobe_n === 1'b0; lo++) @(negedge sys_clk);
    chk("strobe_low", 16'(hs ? LOW_FAST_CYC : LOW_SLOW_CYC), 16'(lo));
    chk("byte", b, got);
  endtask
  task t_por;
    repeat (40) @(negedge sys_clk);
    chk("active_early", 0, port_active);
    repeat (20) @(negedge sys_clk);
    chk("active", 1, port_active);
    chk("printer", 1, printer_mode);
  endtask
  task t_slow;
    // busy and ack outlast the second byte's set-up, so the gap gates decide its strobe
    dly = 8'hfa;
    t_send(1'b0, 8'h3c);
    t_send(1'b0, 8'hff);
  endtask
  task t_fast;
    dly = 8'h96;
    t_send(1'b1, 8'ha5);
    t_send(1'b1, 8'h5a);
  endtask
  task t_ext;
    int i;
    ext_reset_in = 1'b1;
    repeat (10) @(negedge sys_clk);
    ext_reset_in = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("short_ext", 1, port_active);
    ext_reset_in = 1'b1;
    repeat (30) @(negedge sys_clk);
    ext_reset_in = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("ext_hold", 0, port_active);
    for (i = 0; i < 200 && port_active !== 1'b1; i++) @(negedge sys_clk);
    chk("ext_back", 1, port_active);
    t_send(1'b1, 8'h81);
  endtask
  task t_serial;
    rst_n = 1'b0;
    sda_drive_in = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    tx_valid = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk("serial", 1, serial_mode);
    chk("no_ready", 0, tx_ready);
    tx_valid = 1'b0;
    // data pin read high also leaves the printer port off
    rst_n = 1'b0;
    sda_drive_in = 1'b1;
    sda_in = 1'b1;
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk("serial_sda", 1, serial_mode);
    chk("no_printer", 0, printer_mode);
  endtask
  task end_sim;
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  initial begin
    {rst_n, ext_reset_in, high_speed, sda_in, tx_valid} = 5'h00;
    {scl_in, sda_drive_in, tx_data, dly} = 18'h3_0000;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_por;
    t_slow;
    t_fast;
    t_ext;
    t_serial;
    end_sim;
  end
endmodule
`default_nettype wire
